// ### hw/sbsc_pkg.sv
// Package of constants and carrier types for the burst SRAM cycle control
// Summary of operation
// - With the order select low, burst addresses count up modulo four from the start value.
// - With the order select high, burst addresses are the start value XORed with a 0, 1, 2, 3 count.
// - Controller strobe low with primary select high, or a strobe low with primary select low and depth select off, deselects and floats data.
// - Processor strobe low with all selects active starts a read burst at the external address.
// - Processor strobe high, controller strobe low and all selects active start a burst, write if qualifier low.
// - With no strobe starting a cycle and advance low, the counter steps and the next word is read; data drive needs output enable low.
// - A continue cycle with the write qualifier low writes the next burst address, selects and output enable ignored.
// - With no strobe starting a cycle and advance high, the counter holds and the current word is read again.
// - A suspend cycle with the write qualifier low writes the current burst address.
// - Global write low writes all lanes; gate low writes lanes whose strobes are low; otherwise a read.
// - Lane strobe n controls data byte n, lowest strobe on the lowest byte.
// - A processor-strobe cycle is always a read; a write follows on the next wait cycle with the qualifier low.
// - Data drivers stay off from power-up until a read cycle is registered.
// - The primary select gates the processor strobe; with it high the processor strobe is ignored.
package sbsc_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int LANES  = 4;
  localparam logic [1:0] CNT_RESET = 2'h0;
  localparam logic [1:0] CNT_STEP  = 2'h1;
  localparam int READ_LATENCY = 1; // Clocks from address edge to data
  localparam real CLK_PERIOD_NS = 10.0;

  // Cycle types decoded at each edge
  typedef enum logic [3:0] {
    SBSC_DESEL  = 4'h1,
    SBSC_BEGIN  = 4'h2,
    SBSC_CONT   = 4'h4,
    SBSC_SUSP   = 4'h8
  } sbsc_cycle_e;

  // Synchronous control inputs sampled at the clock edge
  typedef struct packed {
    logic                  chip_sel_n;
    logic                  depth_select;
    logic                  depth_select_n;
    logic                  proc_addr_strobe_n;
    logic                  ctrl_addr_strobe_n;
    logic                  burst_step_n;
    logic                  global_write_n;
    logic                  byte_write_gate_n;
    logic [LANES-1:0]      lane_write_n;
  } sbsc_ctrl_s;

  // Read word carried through the output buffer
  typedef struct packed {
    logic [DATA_W-1:0] data;
  } sbsc_word_s;
endpackage : sbsc_pkg

// ### hw/sbsc_buf2.sv
// Two-entry valid/ready buffer for read data
`timescale 1ns/10ps
`default_nettype none
module sbsc_buf2
  import sbsc_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic [1:0]       cnt_q, cnt_d;
  logic             wptr_q, wptr_d, rptr_q, rptr_d;
  logic             push, pop;

  // Next-state of pointers and storage
  always_comb begin
    push   = in_valid_in && (cnt_q != 2'h2);
    pop    = (cnt_q != 2'h0) && out_ready_in;
    mem_d  = mem_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    if (push) begin
      mem_d[wptr_q] = in_data_in;
      wptr_d        = ~wptr_q;
    end
    if (pop) begin
      rptr_d = ~rptr_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  // Register stage
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q    <= 2'h0;
      wptr_q   <= 1'b0;
      rptr_q   <= 1'b0;
    end else begin
      mem_q  <= mem_d;
      cnt_q  <= cnt_d;
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
    end
  end

  assign in_ready_out  = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign out_data_out  = mem_q[rptr_q];
endmodule : sbsc_buf2
`default_nettype wire

// ### hw/sbsc_top.sv
// Cycle control, burst counter, byte-lane writes and data pins of the burst SRAM
`timescale 1ns/10ps
`default_nettype none
module sbsc_top
  import sbsc_pkg::*;
#(
  parameter int DEPTH = 1 << ADDR_W
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rstn_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire sbsc_ctrl_s        ctrl_in,
  input  wire logic              out_enable_n_in,
  input  wire logic              burst_linear_n_in,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic [LANES-1:0]       dq_oe_out,
  output logic                   selected_out,
  input  wire logic              rd_ready_in,
  output logic                   rd_valid_out,
  output logic [DATA_W-1:0]      rd_data_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Storage array and state
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] base_q, base_d;
  logic [1:0]        cnt_q, cnt_d;
  logic [1:0]        start_q, start_d;
  logic              sel_q, sel_d;
  logic              rvalid_q, rvalid_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic [LANES-1:0]  oe_q, oe_d;
  logic              mode_s1_q, mode_s2_q, oen_s1_q, oen_s2_q;
  sbsc_cycle_e       cyc;
  logic [LANES-1:0]  lane_we;
  logic              write_n, all_sel, deselect, begin_burst;
  logic [1:0]        low_bits, cnt_use;
  logic [ADDR_W-1:0] eff_addr;
  logic              buf_ready, buf_valid;
  logic [DATA_W-1:0] buf_data;

  ////////////////////////////////////////////////////////////////////////////
  // Static and asynchronous pins pass two flops before use
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_s1_q <= 1'b1;
      mode_s2_q <= 1'b1;
      oen_s1_q  <= 1'b1;
      oen_s2_q  <= 1'b1;
    end else begin
      mode_s1_q <= burst_linear_n_in;
      mode_s2_q <= mode_s1_q;
      oen_s1_q  <= out_enable_n_in;
      oen_s2_q  <= oen_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle decode
  always_comb begin
    all_sel  = !ctrl_in.chip_sel_n && ctrl_in.depth_select && !ctrl_in.depth_select_n;
    // Primary select gates the processor strobe
    deselect = (!ctrl_in.ctrl_addr_strobe_n && ctrl_in.chip_sel_n) ||
               (!ctrl_in.chip_sel_n && !all_sel &&
                (!ctrl_in.proc_addr_strobe_n || !ctrl_in.ctrl_addr_strobe_n));
    begin_burst = all_sel &&
                  (!ctrl_in.proc_addr_strobe_n || !ctrl_in.ctrl_addr_strobe_n);
    if (deselect) begin
      cyc = SBSC_DESEL;
    end else if (begin_burst) begin
      cyc = SBSC_BEGIN;
    end else if (!ctrl_in.burst_step_n) begin
      cyc = SBSC_CONT;
    end else begin
      cyc = SBSC_SUSP;
    end
  end

  // Write qualifier and lane enables
  always_comb begin
    lane_we = '0;
    if (!ctrl_in.global_write_n) begin
      lane_we = '1;
    end else if (!ctrl_in.byte_write_gate_n) begin
      lane_we = ~ctrl_in.lane_write_n;
    end
    write_n = ~|lane_we;
    // A processor-strobe begin is always a read
    if (cyc == SBSC_BEGIN && !ctrl_in.proc_addr_strobe_n) begin
      lane_we = '0;
    end
    if (cyc == SBSC_DESEL) begin
      lane_we = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst counter and address generation
  always_comb begin
    base_d  = base_q;
    cnt_d   = cnt_q;
    start_d = start_q;
    sel_d   = sel_q;
    case (cyc)
      SBSC_DESEL: begin
        sel_d = 1'b0;
      end
      SBSC_BEGIN: begin
        base_d  = addr_in;
        start_d = addr_in[1:0];
        cnt_d   = CNT_RESET;
        sel_d   = 1'b1;
      end
      SBSC_CONT: begin
        cnt_d = cnt_q + CNT_STEP;
      end
      SBSC_SUSP: begin
        cnt_d = cnt_q;
      end
      default: begin
        cnt_d = cnt_q;
      end
    endcase
    cnt_use = (cyc == SBSC_BEGIN) ? CNT_RESET : cnt_d;
    low_bits = (cyc == SBSC_BEGIN) ? addr_in[1:0] : start_q;
    if (!mode_s2_q) begin
      eff_addr = {((cyc == SBSC_BEGIN) ? addr_in[ADDR_W-1:2] : base_q[ADDR_W-1:2]),
                  2'(low_bits + cnt_use)};
    end else begin
      eff_addr = {((cyc == SBSC_BEGIN) ? addr_in[ADDR_W-1:2] : base_q[ADDR_W-1:2]),
                  low_bits ^ cnt_use};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array write by lane
  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < LANES; i++) begin
      if (lane_we[i] && (cyc != SBSC_DESEL) && (sel_q || cyc == SBSC_BEGIN)) begin
        mem[eff_addr][i*8 +: 8] <= dq_in[i*8 +: 8];
      end
    end
  end

  // Read word and pin drive
  always_comb begin
    rvalid_d = (cyc != SBSC_DESEL) && (sel_q || cyc == SBSC_BEGIN) && write_n;
    if (cyc == SBSC_BEGIN && !ctrl_in.proc_addr_strobe_n) begin
      rvalid_d = 1'b1;
    end
    dout_d = rvalid_d ? mem[eff_addr] : dout_q;
    // Drive only for a registered read and with output enable low
    oe_d = {LANES{rvalid_d && !oen_s2_q}};
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      base_q   <= '0;
      cnt_q    <= CNT_RESET;
      start_q  <= 2'h0;
      sel_q    <= 1'b0;
      rvalid_q <= 1'b0;
      dout_q   <= '0;
      oe_q     <= '0;
    end else begin
      base_q   <= base_d;
      cnt_q    <= cnt_d;
      start_q  <= start_d;
      sel_q    <= sel_d;
      rvalid_q <= rvalid_d && buf_ready;
      dout_q   <= dout_d;
      oe_q     <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data buffer toward the user side
  sbsc_buf2 #(
    .WIDTH (DATA_W)
  ) u_buf (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (rvalid_q),
    .in_ready_out  (buf_ready),
    .in_data_in    (dout_q),
    .out_valid_out (buf_valid),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (buf_data)
  );

  logic              rv_q;
  logic [DATA_W-1:0] rd_q;
  logic              sel_out_q;
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rv_q      <= 1'b0;
      rd_q      <= '0;
      sel_out_q <= 1'b0;
    end else begin
      rv_q      <= buf_valid && rd_ready_in;
      rd_q      <= buf_data;
      sel_out_q <= sel_q;
    end
  end

  assign dq_out       = dout_q;
  assign dq_oe_out    = oe_q;
  assign selected_out = sel_out_q;
  assign rd_valid_out = rv_q;
  assign rd_data_out  = rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_begin;
    (cyc == SBSC_BEGIN);
  endsequence

  a_oe_reset_off: assert property (@(posedge sys_clk_in) !rstn_in |=> dq_oe_out == '0)
    else $error("data driven during reset");
  a_desel_float: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (cyc == SBSC_DESEL) |=> dq_oe_out == '0)
    else $error("data driven after deselect");
  a_begin_loads: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    s_begin |=> (cnt_q == CNT_RESET && base_q == $past(addr_in)))
    else $error("counter not loaded at begin");
  a_cont_step: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (cyc == SBSC_CONT) |=> cnt_q == 2'($past(cnt_q) + 2'h1))
    else $error("counter did not step");
  a_susp_hold: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (cyc == SBSC_SUSP) |=> $stable(cnt_q))
    else $error("counter moved in wait");
  a_proc_read: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (s_begin and !ctrl_in.proc_addr_strobe_n) |-> lane_we == '0)
    else $error("write on processor begin");
  a_global_all: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (!ctrl_in.global_write_n && cyc == SBSC_CONT && sel_q) |-> lane_we == '1)
    else $error("global write not all lanes");
  a_oe_gates: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    oen_s2_q |=> dq_oe_out == '0)
    else $error("driven with output enable high");
  a_prim_gate: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ctrl_in.chip_sel_n && ctrl_in.ctrl_addr_strobe_n) |-> cyc != SBSC_BEGIN)
    else $error("begin with primary select high");
endmodule : sbsc_top
`default_nettype wire

// ### tb/sbsc_ctl_model.sv
// Controller model that drives cycles and shares the data bus with the burst SRAM
`timescale 1ns/10ps
`default_nettype none
module sbsc_ctl_model
  import sbsc_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic [DATA_W-1:0] dq_out_in,
  input  wire logic [LANES-1:0]  dq_oe_in,
  output sbsc_ctrl_s             ctrl_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   oe_n_out,
  output logic [DATA_W-1:0]      bus_out
);
  logic [DATA_W-1:0] wdata  = '0;
  logic              wdrive = 1'b0;
  logic [DATA_W-1:0] last   = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Idle levels from time zero: no strobe, output enable off
  initial begin
    ctrl_out = '{chip_sel_n: 1'b1, depth_select: 1'b1, depth_select_n: 1'b0,
      proc_addr_strobe_n: 1'b1, ctrl_addr_strobe_n: 1'b1, burst_step_n: 1'b1,
      global_write_n: 1'b1, byte_write_gate_n: 1'b1, lane_write_n: 4'hF};
    addr_out = '0;
    oe_n_out = 1'b1;
  end
  // Per-lane bus level; a lane nobody drives shows the inverse of its last level
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      if (dq_oe_in[i]) bus_out[i*8+:8] = dq_out_in[i*8+:8];
      else if (wdrive) bus_out[i*8+:8] = wdata[i*8+:8];
      else bus_out[i*8+:8] = ~last[i*8+:8];
    end
  end
  // Remember the bus so a floating lane can be shown as changing
  always @(posedge sys_clk_in) last <= bus_out;
  ////////////////////////////////////////////////////////////////////////////
  // One bus cycle: c = {depth off, select_n, proc_n, ctrl_n, step_n}
  // w = {global_n, gate_n, lanes_n}; driven off the falling edge
  task automatic cyc(input logic [4:0] c, input logic [1:0] lo, input logic [5:0] w,
                     input logic [DATA_W-1:0] d);
    @(negedge sys_clk_in);
    ctrl_out = '{chip_sel_n: c[3], depth_select: !c[4], depth_select_n: c[4],
      proc_addr_strobe_n: c[2], ctrl_addr_strobe_n: c[1], burst_step_n: c[0],
      global_write_n: w[5], byte_write_gate_n: w[4], lane_write_n: w[3:0]};
    addr_out = {15'h0041, lo};
    wdata = d;
    // Write data only goes out while output enable is high, so the bus is free
    wdrive = oe_n_out && (!w[5] || (!w[4] && w[3:0] != 4'hF));
  endtask
endmodule // sbsc_ctl_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking testbench for the burst SRAM cycle control
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import sbsc_pkg::*;
;
  localparam logic [4:0] BEG_P = 5'h03, BEG_C = 5'h05, CONT = 5'h06, CONT_CSH = 5'h0E;
  localparam logic [4:0] SUSP = 5'h07, DESEL = 5'h0D, DSEL2 = 5'h15, P_CSH = 5'h0B;
  localparam logic [5:0] RD = 6'h3F, WR_ALL = 6'h1F, B0 = 6'h2E, B3 = 6'h27;
  logic              sys_clk_in = 1'b0;
  logic              rstn_in    = 1'b0;
  logic              rd_ready_in = 1'b0;
  logic              lin_n      = 1'b0;
  sbsc_ctrl_s        ctrl;
  logic [ADDR_W-1:0] addr;
  logic              oe_n;
  logic [DATA_W-1:0] bus, dq_out, rd_data;
  logic [LANES-1:0]  dq_oe;
  logic              rd_valid;
  logic              sel;
  logic [DATA_W-1:0] mem [4];
  int                fails = 0;
  int                checks_done = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and controller model
  always #(CLK_PERIOD_NS / 2) sys_clk_in = ~sys_clk_in;
  sbsc_top uut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr),
    .ctrl_in(ctrl), .out_enable_n_in(oe_n), .burst_linear_n_in(lin_n), .dq_in(bus),
    .dq_out(dq_out), .dq_oe_out(dq_oe), .selected_out(sel), .rd_ready_in(rd_ready_in),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data));
  sbsc_ctl_model ctl (.sys_clk_in(sys_clk_in), .dq_out_in(dq_out), .dq_oe_in(dq_oe),
    .ctrl_out(ctrl), .addr_out(addr), .oe_n_out(oe_n), .bus_out(bus));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Deselect cycles; output enable moves only once the pending request is taken,
  // so write data still on the bus is captured before the bus changes hands
  task automatic idle(input int n, input logic oe_off);
    ctl.cyc(DESEL, 2'h0, RD, '0);
    ctl.oe_n_out = oe_off;
    repeat (n - 1) ctl.cyc(DESEL, 2'h0, RD, '0);
  endtask
  // Burst write from start s with full-word writes
  task automatic t_wr(input logic [1:0] s);
    for (int k = 0; k < 4; k++) begin
      ctl.cyc(k == 0 ? BEG_C : CONT, s, WR_ALL, 32'(32'h11111111 * (k + 1)));
      mem[s + 2'(k)] = 32'(32'h11111111 * (k + 1));
      chk({28'h0, dq_oe}, 32'h0);
    end
  endtask
  // Read burst of four words; each word stands on the pins after the edge that took it
  task automatic rd_burst(input logic [1:0] s);
    logic [1:0] idx;
    ctl.cyc(BEG_P, s, RD, '0);
    for (int k = 0; k < 6; k++) begin
      ctl.cyc(k < 3 ? CONT : DESEL, 2'h0, RD, '0);
      idx = lin_n ? s ^ 2'(k) : s + 2'(k);
      if (k < 4) chk(dq_out, mem[idx]);
      if (k < 4) chk({28'h0, dq_oe}, 32'h0000000F);
      if (k == 1) chk({31'h0, sel}, 32'h1);
    end
    chk({28'h0, dq_oe}, 32'h0);
    chk({31'h0, sel}, 32'h0);
  endtask
  // Wait cycle holds the address; primary select high blocks the processor strobe
  task automatic t_susp();
    ctl.cyc(BEG_P, 2'h0, RD, '0);
    ctl.cyc(P_CSH, 2'h2, RD, '0);
    ctl.cyc(CONT, 2'h0, RD, '0);
    chk(dq_out, mem[0]);
    ctl.cyc(DESEL, 2'h0, RD, '0);
    chk(dq_out, mem[1]);
    ctl.cyc(DESEL, 2'h0, RD, '0);
    chk({28'h0, dq_oe}, 32'h0);
  endtask
  // Processor begin stays a read; byte writes follow; deselects write nothing
  task automatic t_byte();
    ctl.cyc(BEG_P, 2'h3, WR_ALL, 32'hEEEEEEEE);
    ctl.cyc(SUSP, 2'h0, B0, 32'h000000A5);
    chk(dq_out, mem[3]);
    chk({28'h0, dq_oe}, 32'h0);
    ctl.cyc(CONT_CSH, 2'h0, B3, 32'h5A000000);
    mem[3][7:0] = 8'hA5;
    mem[0][31:24] = 8'h5A;
    ctl.cyc(DESEL, 2'h1, WR_ALL, 32'hFFFFFFFF);
    ctl.cyc(DSEL2, 2'h2, WR_ALL, 32'hFFFFFFFF);
  endtask
  // Stalled reader: buffer keeps two words, then drains empty
  task automatic t_buf();
    int n;
    n = 0;
    rd_ready_in = 1'b1;
    idle(4, 1'b0);
    rd_ready_in = 1'b0;
    rd_burst(2'h0);
    rd_ready_in = 1'b1;
    repeat (6) begin
      ctl.cyc(DESEL, 2'h0, RD, '0);
      if (rd_valid === 1'b1 && n < 4) begin
        chk(rd_data, mem[n]);
        n++;
      end
    end
    chk(32'(n), 32'h2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rstn_in = 1'b1;
    chk({28'h0, dq_oe}, 32'h0);
    idle(3, 1'b1);
    t_wr(2'h1);
    idle(3, 1'b0);
    rd_burst(2'h2);
    t_susp();
    lin_n = 1'b1;
    idle(4, 1'b0);
    rd_burst(2'h1);
    lin_n = 1'b0;
    idle(4, 1'b1);
    t_byte();
    idle(3, 1'b0);
    rd_burst(2'h3);
    t_buf();
    end_of_test();
  end
  // Watchdog well beyond the fewer than 100 cycles the tests need
  initial begin
    #(2000 * CLK_PERIOD_NS);
    fails++;
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
